/* File: core/spy_memory_controller.sv */
`default_nettype none

// Stream buffer; flags are registered so inReady and outValid both come from flops.
module spy_stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output var  logic             inReady,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outValid_unused_n,
  output var  logic             outValid,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             push;
  logic             pop;

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = store[rdPtr_q];

  // Next fill level; push and pop together leave it unchanged.
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Pointers, level and the registered full and empty flags.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_d;
      inReady <= count_d != (PW + 1)'(DEPTH);
      outValid <= count_d != '0;
    end
  end

  // Storage has no reset; only written slots are ever shown.
  always_ff @(posedge core_clk) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end

endmodule

module spy_memory_controller
  import spy_mem_pkg::*;
#(
  parameter mem_kind_t   MEM_KIND = kindStd,
  parameter logic [15:0] BASE_PAGE = 16'h0000
) (
  input  wire logic     core_clk,
  input  wire logic     reset,
  input  wire reg_req_t regReq,
  output var  reg_rsp_t regRsp,
  input  wire logic     timingStartReplay,
  input  wire frame_t   upFrame,
  input  wire logic     upValid,
  output var  logic     upReady,
  output var  frame_t   dnFrame,
  output var  logic     dnValid,
  input  wire logic     dnReady
);

  // Depth follows the memory kind; only backplane forwarded memories use two slots per event.
  localparam int DEPTH = (MEM_KIND == kindFwdBackplane) ? DEPTH_FWD_BP : DEPTH_STD;
  localparam logic [LOC_W-1:0] LAST_LOC = LOC_W'(DEPTH - 1);
  localparam logic [ACC_W-1:0] LAST_ACC = ACC_W'(CHAN_COUNT * DEPTH - 1);
  localparam bit REPLAY_OK = (MEM_KIND == kindStd);

  function automatic logic [IDX_W-1:0] memIdx(input int ch, input logic [LOC_W-1:0] loc);
    memIdx = IDX_W'(ch * DEPTH_FWD_BP + int'(loc));
  endfunction

  function automatic logic [3:0] stateCode(input ctl_state_t s);
    case (s)
      stIdleRun:    stateCode = CODE_IDLE_RUN;
      stAccessBusy: stateCode = CODE_ACCESS_BUSY;
      stReadReady:  stateCode = CODE_READ_READY;
      stWriteReady: stateCode = CODE_WRITE_READY;
      default:      stateCode = CODE_IDLE_RUN;
    endcase
  endfunction

  logic [WORD_W-1:0] mem [CHAN_COUNT * DEPTH_FWD_BP];

  ctl_state_t                           state_q;
  logic [5:0]                           ctrl_q;
  logic                                 freeze_q;
  logic [15:0]                          start_q;
  logic [ACC_W-1:0]                     acc_q;
  logic                                 dirWrite_q;
  logic [DATA_REG_COUNT-1:0][REG_W-1:0] words_q;
  logic [LOC_W-1:0]                     bLoc_q;
  frame_t                               hold_q;
  logic [CHAN_COUNT-1:0]                errFlag_q;
  logic [CHAN_COUNT-1:0][15:0]          errCnt_q;

  logic             hit;
  logic [7:0]       ofs;
  logic             wrCtl;
  logic             rdTop;
  logic             wrTop;
  logic             accLast;
  int               accCh;
  logic [LOC_W-1:0] accLoc;
  logic [3:0]       mode;
  logic             isCapture;
  logic             isReplay;
  logic             isCompare;
  logic             suspended;
  logic             fifoReady;
  logic             move;
  logic             advance;
  logic             capWr;
  frame_t           bRead;
  frame_t           pushFrame;
  logic [CHAN_COUNT-1:0] mismatch;
  logic [CHAN_COUNT-1:0] errClr;
  logic [15:0]      rdData;

  // Only single 16-bit cycles inside our page are decoded.
  assign hit = regReq.stb && (regReq.addr[23:8] == BASE_PAGE);
  assign ofs = regReq.addr[7:0];
  assign wrCtl = hit && regReq.wr && (ofs == OFS_CONTROL);
  assign rdTop = hit && !regReq.wr && (ofs == OFS_WORD_TOP);
  assign wrTop = hit && regReq.wr && (ofs == OFS_WORD_TOP);
  assign errClr = (hit && regReq.wr && (ofs == OFS_ERRFLAG)) ? regReq.wdata[CHAN_COUNT-1:0] : '0;

  // Flat access address; with 256 slots this splits into event and channel fields.
  assign accLast = (acc_q == LAST_ACC);
  assign accCh = int'(acc_q) / DEPTH;
  assign accLoc = LOC_W'(int'(acc_q) % DEPTH);

  // Mode decode straight from the stored bits so the muxes follow a write at once.
  assign mode = ctrl_q[3:0];
  assign isCapture = (mode == MODE_CAPTURE);
  assign isReplay = (mode == MODE_REPLAY) && REPLAY_OK;
  assign isCompare = (mode == MODE_COMPARE);
  assign suspended = (state_q != stIdleRun);

  // A slot moves when the buffer accepts it; replay does not wait on the source.
  assign move = fifoReady && (isReplay || upValid);
  assign advance = move && !suspended;
  assign capWr = advance && isCapture && !freeze_q;
  assign upReady = fifoReady;

  // Port B reads are combinational so compare and replay see the current slot.
  always_comb begin
    for (int ch = 0; ch < CHAN_COUNT; ch++) begin
      bRead.chan[ch] = mem[memIdx(ch, bLoc_q)];
      mismatch[ch] = upFrame.chan[ch] != bRead.chan[ch];
    end
  end

  // Replay sends memory words and drops upstream; paused replay repeats the last word.
  always_comb begin
    if (isReplay) begin
      pushFrame = suspended ? hold_q : bRead;
    end else begin
      pushFrame = upFrame;
    end
  end

  spy_stream_fifo #(
    .WIDTH($bits(frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk         (core_clk),
    .reset            (reset),
    .inData           (pushFrame),
    .inValid          (move),
    .inReady          (fifoReady),
    .outData          (dnFrame),
    .outValid_unused_n(1'b0),
    .outValid         (dnValid),
    .outReady         (dnReady)
  );

  // Control, freeze and start registers; the request bit drops when an access finishes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= CONTROL_RESET;
      freeze_q <= 1'b0;
      start_q <= START_RESET;
    end else begin
      if (wrCtl) begin
        ctrl_q <= regReq.wdata[5:0];
      end else if (suspended && state_q != stAccessBusy && (rdTop || wrTop) && accLast) begin
        ctrl_q[CTL_REQ_BIT] <= 1'b0;
      end
      if (hit && regReq.wr && ofs == OFS_FREEZE) begin
        freeze_q <= regReq.wdata[FREEZE_BIT];
      end
      if (hit && regReq.wr && ofs == OFS_START) begin
        start_q <= regReq.wdata;
      end
    end
  end

  // Access sequencer; requests made outside idle running are ignored.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= stIdleRun;
      acc_q <= '0;
      dirWrite_q <= 1'b0;
    end else begin
      case (state_q)
        stIdleRun: begin
          if (wrCtl && regReq.wdata[CTL_REQ_BIT]) begin
            acc_q <= '0;
            dirWrite_q <= regReq.wdata[CTL_DIR_BIT];
            state_q <= regReq.wdata[CTL_DIR_BIT] ? stWriteReady : stAccessBusy;
          end
        end
        stAccessBusy: begin
          if (!dirWrite_q) begin
            state_q <= stReadReady;
          end else if (accLast) begin
            state_q <= stIdleRun;
          end else begin
            acc_q <= acc_q + 1'b1;
            state_q <= stWriteReady;
          end
        end
        stReadReady: begin
          if (rdTop && accLast) begin
            state_q <= stIdleRun;
          end else if (rdTop) begin
            acc_q <= acc_q + 1'b1;
            state_q <= stAccessBusy;
          end
        end
        stWriteReady: begin
          if (wrTop) begin
            state_q <= stAccessBusy;
          end
        end
        default: state_q <= stIdleRun;
      endcase
    end
  end

  // Data registers: written by the host, loaded from memory in the busy read step.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      words_q <= '0;
    end else if (state_q == stAccessBusy && !dirWrite_q) begin
      words_q <= mem[memIdx(accCh, accLoc)];
    end else begin
      for (int w = 0; w < DATA_REG_COUNT; w++) begin
        if (hit && regReq.wr && ofs == OFS_WORD + 8'(2 * w)) begin
          words_q[w] <= regReq.wdata;
        end
      end
    end
  end

  // One write process for both ports; port B is idle whenever port A writes.
  always_ff @(posedge core_clk) begin
    if (state_q == stAccessBusy && dirWrite_q) begin
      mem[memIdx(accCh, accLoc)] <= words_q;
    end else if (capWr) begin
      for (int ch = 0; ch < CHAN_COUNT; ch++) begin
        mem[memIdx(ch, bLoc_q)] <= upFrame.chan[ch];
      end
    end
  end

  // Cyclic port B address; the timing command takes priority over stepping.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bLoc_q <= '0;
    end else if (timingStartReplay) begin
      bLoc_q <= LOC_W'(int'(start_q) % DEPTH);
    end else if (advance) begin
      bLoc_q <= (bLoc_q == LAST_LOC) ? '0 : bLoc_q + 1'b1;
    end
  end

  // Last replayed word, repeated while an access holds the memory.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_q <= '0;
    end else if (advance && isReplay) begin
      hold_q <= bRead;
    end
  end

  // Compare errors: a mismatch in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      errFlag_q <= '0;
      errCnt_q <= '0;
    end else begin
      for (int ch = 0; ch < CHAN_COUNT; ch++) begin
        if (advance && isCompare && mismatch[ch]) begin
          errFlag_q[ch] <= 1'b1;
          if (errClr[ch]) begin
            errCnt_q[ch] <= 16'h0001;
          end else if (errCnt_q[ch] != COUNT_MAX) begin
            errCnt_q[ch] <= errCnt_q[ch] + 1'b1;
          end
        end else if (errClr[ch]) begin
          errFlag_q[ch] <= 1'b0;
          errCnt_q[ch] <= '0;
        end
      end
    end
  end

  // Read mux; unmapped offsets read as zero but are still acknowledged.
  always_comb begin
    rdData = '0;
    case (ofs)
      OFS_CONTROL: rdData = {10'h000, ctrl_q};
      OFS_STATE:   rdData = {stateCode(state_q), acc_q};
      OFS_FREEZE:  rdData = {15'h0000, freeze_q};
      OFS_START:   rdData = start_q;
      OFS_ERRFLAG: rdData = 16'(errFlag_q);
      default: begin
        for (int ch = 0; ch < CHAN_COUNT; ch++) begin
          if (ofs == OFS_ERRCNT + 8'(2 * ch)) begin
            rdData = errCnt_q[ch];
          end
        end
        for (int w = 0; w < DATA_REG_COUNT; w++) begin
          if (ofs == OFS_WORD + 8'(2 * w)) begin
            rdData = words_q[w];
          end
        end
      end
    endcase
  end

  // Answer one cycle after the strobe, from flops.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRsp <= '0;
    end else begin
      regRsp.ack <= hit;
      regRsp.rdata <= (hit && !regReq.wr) ? rdData : '0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  readStart_a: assert property (state_q == stIdleRun && wrCtl && regReq.wdata[5:4] == 2'b01
    |=> state_q == stAccessBusy ##1 state_q == stReadReady && acc_q == '0)
    else $error("read request did not reach read-ready at zero");

  writeStart_a: assert property (state_q == stIdleRun && wrCtl && regReq.wdata[5:4] == 2'b11
    |=> state_q == stWriteReady && acc_q == '0)
    else $error("write request did not reach write-ready at zero");

  readStep_a: assert property (state_q == stReadReady && rdTop && !accLast
    |=> state_q == stAccessBusy && acc_q == $past(acc_q) + 1'b1 ##1 state_q == stReadReady)
    else $error("read step did not fetch next address");

  readEnd_a: assert property (state_q == stReadReady && rdTop && accLast |=> state_q == stIdleRun)
    else $error("last read did not return to idle");

  writeEnd_a: assert property (state_q == stWriteReady && wrTop && accLast
    |=> state_q == stAccessBusy ##1 state_q == stIdleRun)
    else $error("last write did not return to idle");

  // Channel 0 of the slot under port B must keep its word across a frozen cycle, whatever the mode.
  freezeBlock_a: assert property (freeze_q && !suspended
    |=> mem[memIdx(0, $past(bLoc_q))] == $past(bRead.chan[0]))
    else $error("capture wrote while frozen");

  suspendBlock_a: assert property (suspended && !timingStartReplay |-> !capWr ##1 bLoc_q == $past(bLoc_q))
    else $error("port B moved during an access");

  startReload_a: assert property (timingStartReplay |=> bLoc_q == LOC_W'(int'($past(start_q)) % DEPTH))
    else $error("start command did not reload port B address");

  modeSwitch_a: assert property (wrCtl |=> mode == $past(regReq.wdata[3:0]))
    else $error("mode did not follow control write");

  compareFlag_a: assert property (advance && isCompare && mismatch[0] |=> errFlag_q[0])
    else $error("mismatch did not set the sticky flag");

  replayHold_a: assert property (move && isReplay && suspended |-> pushFrame == hold_q)
    else $error("suspended replay did not repeat its word");

  readCycle_c: cover property (state_q == stReadReady ##1 rdTop ##[1:4] state_q == stReadReady);
  writeCycle_c: cover property (state_q == stWriteReady && wrTop ##2 state_q == stWriteReady);
  compareErr_c: cover property (advance && isCompare && mismatch != '0);
  fifoFull_c: cover property (!fifoReady && upValid);

endmodule

`default_nettype wire

/* File: inc/spy_mem_pkg.sv */
// Function
// - Register port takes only 24-bit address, 16-bit data cycles from one master.
// - Forwarded-clock backplane memory has 512 locations, two per event.
// - All other memories have 256 locations, one event per location.
// - Port B steps cyclically; port A serves register programming and readout.
// - Forwarded-clock memories offer capture and compare only, never replay.
// - Start-of-replay timing command reloads the port B address from start register.
// - Freeze bit 0 blocks all capture writes together and synchronously.
// - Capture writes stop while a register access to the memory runs.
// - Capture passes upstream data downstream unchanged and stores it cyclically.
// - Replay drops upstream data and sends memory words downstream.
// - Compare forwards upstream data; mismatches bump counters and set sticky flags.
// - Control bits 3 to 0 select mode; data muxes switch on write.
// - Control bit 4 requests access, bit 5 picks read or write.
// - Status low 12 bits give next address: event 7..0, channel 11..8; backplane memory gives location 8..0, channel 11..9.
// - Status upper four bits give the controller state code.
// - Read request suspends cycling, fetches address zero, then shows read-ready.
// - Suspended capture keeps data flowing unstored; suspended replay repeats output.
// - Reading top data register fetches next location and increments the address.
// - Reading top data register at last address returns to idle running.
// - Write request shows write-ready at zero; top register write stores and steps.
// - Top register write at last location stores and returns to idle running.
`default_nettype none
package spy_mem_pkg;

  localparam int DATA_REG_COUNT = 2;
  localparam int REG_W = 16;
  localparam int WORD_W = DATA_REG_COUNT * REG_W;
  localparam int CHAN_COUNT = 2;
  localparam int DEPTH_FWD_BP = 512;
  localparam int DEPTH_STD = 256;
  localparam int LOC_W = 9;
  localparam int ACC_W = 12;
  localparam int IDX_W = 10;
  localparam int FIFO_DEPTH = 16;

  // Register offsets inside the block's 256-byte window.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h02;
  localparam logic [7:0] OFS_FREEZE = 8'h04;
  localparam logic [7:0] OFS_START = 8'h06;
  localparam logic [7:0] OFS_ERRFLAG = 8'h08;
  localparam logic [7:0] OFS_ERRCNT = 8'h0A;
  localparam logic [7:0] OFS_WORD = 8'h20;
  localparam logic [7:0] OFS_WORD_TOP = 8'h22;

  localparam int CTL_REQ_BIT = 4;
  localparam int CTL_DIR_BIT = 5;
  localparam int FREEZE_BIT = 0;
  localparam logic [5:0] CONTROL_RESET = 6'h01;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam logic [3:0] MODE_CAPTURE = 4'h1;
  localparam logic [3:0] MODE_REPLAY = 4'h2;
  localparam logic [3:0] MODE_COMPARE = 4'h3;

  localparam logic [3:0] CODE_IDLE_RUN = 4'h0;
  localparam logic [3:0] CODE_ACCESS_BUSY = 4'h1;
  localparam logic [3:0] CODE_READ_READY = 4'h2;
  localparam logic [3:0] CODE_WRITE_READY = 4'h3;

  typedef enum logic [1:0] {
    stIdleRun = 2'h0, stAccessBusy = 2'h1, stReadReady = 2'h3, stWriteReady = 2'h2
  } ctl_state_t;

  typedef enum logic [1:0] {kindFwdBackplane = 2'h0, kindFwdRear = 2'h1, kindStd = 2'h2} mem_kind_t;

  typedef struct packed {
    logic        stb;
    logic        wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [CHAN_COUNT-1:0][WORD_W-1:0] chan;
  } frame_t;

endpackage
`default_nettype wire

/* File: verif/spy_host_model.sv */
`default_nettype none
// Crate master on the reduced register bus: one strobe per access, nothing else.
module spy_host_model
  import spy_mem_pkg::*;
#(
  parameter logic [15:0] PAGE = 16'h0000
) (
  input  wire logic     core_clk,
  output var  reg_req_t regReq,
  input  wire reg_rsp_t regRsp
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus starts quiet.
  initial regReq = '0;

  // A24/D16 access: strobe for one cycle, answer taken at the following edge.
  task automatic access(input logic wr, input logic [7:0] ofs, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ack);
    regReq = '{stb: 1'b1, wr: wr, addr: {PAGE, ofs}, wdata: wd};
    @(posedge core_clk);
    #1;
    // Released fields show inverted values so nothing can lean on a stale bus.
    regReq = '{stb: 1'b0, wr: ~wr, addr: {~PAGE, ~ofs}, wdata: ~wd};
    @(posedge core_clk);
    rd = regRsp.rdata;
    ack = regRsp.ack;
    #1;
  endtask

  // A memory request is made once the controller runs idle, or after 50 retries.
  task automatic request(input logic [15:0] ctl, output logic ack);
    logic [15:0] s;
    int          n;
    n = 0;
    access(1'b0, OFS_STATE, 16'h0000, s, ack);
    while (s[15:12] !== CODE_IDLE_RUN && n < 50) begin
      access(1'b0, OFS_STATE, 16'h0000, s, ack);
      n++;
    end
    access(1'b1, OFS_CONTROL, ctl, s, ack);
  endtask

  // Word registers are read lowest first, since the top one advances the address.
  task automatic readWord(output logic [31:0] w);
    logic ack;
    access(1'b0, OFS_WORD, 16'h0000, w[15:0], ack);
    access(1'b0, OFS_WORD_TOP, 16'h0000, w[31:16], ack);
  endtask
endmodule
`default_nettype wire

/* File: verif/spy_memory_controller_tb.sv */
`default_nettype none
module spy_memory_controller_tb
  import spy_mem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic     core_clk = 1'b0;
  logic     reset = 1'b1;
  reg_req_t regReq;
  reg_rsp_t regRsp;
  logic     timingStartReplay = 1'b0;
  frame_t   upFrame = '0;
  logic     upValid = 1'b0;
  logic     upReady;
  frame_t   dnFrame;
  logic     dnValid;
  logic     dnReady = 1'b1;
  logic     dnEn = 1'b1;
  logic     stall = 1'b0;
  int       error_cnt = 0;
  int       num_checks = 0;
  int       cyc = 0;
  frame_t   dq[$];
  frame_t   eq[$];

  spy_memory_controller #(
    .MEM_KIND  (kindStd),
    .BASE_PAGE (16'h0000)
  ) u_spy_memory_controller (
    .core_clk          (core_clk),
    .reset             (reset),
    .regReq            (regReq),
    .regRsp            (regRsp),
    .timingStartReplay (timingStartReplay),
    .upFrame           (upFrame),
    .upValid           (upValid),
    .upReady           (upReady),
    .dnFrame           (dnFrame),
    .dnValid           (dnValid),
    .dnReady           (dnReady)
  );

  spy_host_model #(
    .PAGE (16'h0000)
  ) u_spy_host_model (
    .core_clk (core_clk),
    .regReq   (regReq),
    .regRsp   (regRsp)
  );

  // Free-running clock with a 10 ns period.
  always #5 core_clk = ~core_clk;

  // Cycle count; a hang ends the run as a failure.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Sink readiness, stalled two cycles in four when asked.
  always @(posedge core_clk) begin
    #1;
    dnReady = dnEn && !(stall && cyc[1]);
  end

  // Everything handed downstream is kept in arrival order.
  always @(posedge core_clk) begin
    if (dnValid === 1'b1 && dnReady === 1'b1) dq.push_back(dnFrame);
  end

  // Loaded pattern at slot k: channel 0 at address k, channel 1 one depth higher.
  function automatic frame_t mkPat(input logic [15:0] k);
    frame_t      f;
    logic [15:0] b;
    b = k + 16'(DEPTH_STD);
    f.chan[0] = {k ^ 16'h5A5A, k};
    f.chan[1] = {b ^ 16'h5A5A, b};
    return f;
  endfunction

  // Upstream filler that never matches the loaded pattern.
  function automatic frame_t junk(input logic [15:0] i);
    return frame_t'({4{i ^ 16'hC3A0}});
  endfunction

  task automatic chkReg(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkFrame(input string what, input frame_t exp, input frame_t got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [15:0] d);
    logic a;
    u_spy_host_model.access(1'b0, ofs, 16'h0000, d, a);
    chkReg("read ack", 16'h0001, {15'h0000, a});
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
    logic [15:0] r;
    logic        a;
    u_spy_host_model.access(1'b1, ofs, d, r, a);
    chkReg("write ack", 16'h0001, {15'h0000, a});
  endtask

  task automatic rdChk(input string what, input logic [7:0] ofs, input logic [15:0] exp);
    logic [15:0] d;
    rd(ofs, d);
    chkReg(what, exp, d);
  endtask

  // Valid stays up between back-to-back words; the caller lowers it after the last.
  task automatic push(input frame_t f);
    upFrame = f;
    upValid = 1'b1;
    eq.push_back(f);
    @(posedge core_clk);
    while (upReady !== 1'b1) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse();
    timingStartReplay = 1'b1;
    @(posedge core_clk);
    #1;
    timingStartReplay = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Busy is retried a bounded number of times before the state is judged.
  task automatic waitState(input logic [3:0] code, input logic [11:0] adr);
    logic [15:0] s;
    int          n;
    n = 0;
    rd(OFS_STATE, s);
    while (s[15:12] === CODE_ACCESS_BUSY && n < 20) begin
      rd(OFS_STATE, s);
      n++;
    end
    chkReg("status", {code, adr}, s);
  endtask

  task automatic flushChk(input string what);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (dq.size() < eq.size() && n < 200);
    #1;
    chkReg(what, 16'(eq.size()), 16'(dq.size()));
    foreach (eq[i]) if (i < dq.size()) chkFrame(what, eq[i], dq[i]);
    eq.delete();
    dq.delete();
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    logic [15:0] s;
    logic [31:0] w;
    logic        a;
    frame_t      f;
    int          jumps;
    repeat (12) @(posedge core_clk);
    #1;
    reset = 1'b0;
    // Values after reset, and an unmapped offset that reads as zero.
    rdChk("control", OFS_CONTROL, 16'h0001);
    rdChk("status", OFS_STATE, 16'h0000);
    rdChk("freeze", OFS_FREEZE, 16'h0000);
    rdChk("start", OFS_START, 16'h0000);
    rdChk("unmapped", 8'h40, 16'h0000);
    // Capture: fill the buffer until it refuses, then drain with stalls.
    dnEn = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) push(junk(i[15:0]));
    upValid = 1'b0;
    idle(3);
    chkReg("upReady", 16'h0000, {15'h0000, upReady});
    stall = 1'b1;
    dnEn = 1'b1;
    for (int i = 16; i < 24; i++) push(junk(i[15:0]));
    upValid = 1'b0;
    flushChk("capture");
    stall = 1'b0;
    // Load the whole memory through the word registers.
    u_spy_host_model.request(16'h0031, a);
    for (int k = 0; k < 2 * DEPTH_STD; k++) begin
      waitState(CODE_WRITE_READY, k[11:0]);
      wr(OFS_WORD, k[15:0]);
      wr(OFS_WORD_TOP, k[15:0] ^ 16'h5A5A);
    end
    rd(OFS_STATE, s);
    chkReg("state after load", {12'h000, CODE_IDLE_RUN}, {12'h000, s[15:12]});
    // Frozen capture: words still flow, the memory keeps its pattern.
    wr(OFS_FREEZE, 16'h0001);
    rdChk("freeze", OFS_FREEZE, 16'h0001);
    for (int i = 0; i < 8; i++) push(junk(16'h0100 + i[15:0]));
    upValid = 1'b0;
    wr(OFS_FREEZE, 16'h0000);
    flushChk("frozen");
    // Read everything back; words pushed mid-read pass but are not stored.
    u_spy_host_model.request(16'h0011, a);
    for (int k = 0; k < 2 * DEPTH_STD; k++) begin
      waitState(CODE_READ_READY, k[11:0]);
      if (k == 0) begin
        for (int i = 0; i < 3; i++) push(junk(16'h0200 + i[15:0]));
        upValid = 1'b0;
      end
      u_spy_host_model.readWord(w);
      chkReg("word low", k[15:0], w[15:0]);
      chkReg("word high", k[15:0] ^ 16'h5A5A, w[31:16]);
    end
    rd(OFS_STATE, s);
    chkReg("state after read", {12'h000, CODE_IDLE_RUN}, {12'h000, s[15:12]});
    rdChk("control", OFS_CONTROL, 16'h0001);
    flushChk("suspended");
    // Compare from slot 0: one match, then a channel 1 mismatch.
    wr(OFS_START, 16'h0000);
    pulse();
    wr(OFS_CONTROL, {12'h000, MODE_COMPARE});
    push(mkPat(16'h0000));
    f = mkPat(16'h0001);
    f.chan[1][0] = ~f.chan[1][0];
    push(f);
    upValid = 1'b0;
    flushChk("compare");
    rdChk("error flags", OFS_ERRFLAG, 16'h0002);
    rdChk("error count 0", OFS_ERRCNT, 16'h0000);
    rdChk("error count 1", OFS_ERRCNT + 8'h02, 16'h0001);
    // Replay into a blocked sink, then restart the cycle at slot 0x30.
    // Upstream is raised only once replay holds, so no compare-mode word slips in first.
    dnEn = 1'b0;
    wr(OFS_CONTROL, {12'h000, MODE_REPLAY});
    upFrame = junk(16'h0300);
    upValid = 1'b1;
    idle(30);
    wr(OFS_START, 16'h0030);
    pulse();
    dnEn = 1'b1;
    idle(20);
    upValid = 1'b0;
    wr(OFS_CONTROL, 16'h0001);
    idle(20);
    jumps = 0;
    chkFrame("first replay slot", mkPat(16'h0002), dq[0]);
    for (int i = 1; i < dq.size(); i++) begin
      chkFrame("replay word", mkPat(dq[i].chan[0][15:0]), dq[i]);
      if (dq[i].chan[0][15:0] !== dq[i-1].chan[0][15:0] + 16'h0001) begin
        jumps++;
        chkReg("restart slot", 16'h0030, dq[i].chan[0][15:0]);
      end
    end
    chkReg("restarts", 16'h0001, 16'(jumps));
    report_and_stop();
  end
endmodule
`default_nettype wire
